// file: hw/rxgt_top.sv
// Receive gain settings, mask receive timer and no-response timer.
//
// Implementation choice: the APB slave port.
`timescale 1ns/1ps
module rxgt_top
    import rxgt_pkg::*;
(
    // APB clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Transceiver events, pins
    input wire logic tx_end_pin,
    input wire logic ext_field_pin,
    input wire logic rx_start_pin,
    input wire logic rx_data_pin,
    // Receive path outputs
    output logic rx_data_masked,
    output logic mask_active,
    output logic squelch_active,
    output logic [1:0] am_window,
    output logic [2:0] am_stage_cut,
    output logic [1:0] pm_window,
    output logic [2:0] pm_stage_cut,
    output logic [3:0] am_stage23_gain_code,
    output logic [3:0] pm_stage23_gain_code,
    output logic no_response_irq
);
    // ------------------------------------------------------------------
    // Pin synchronisers: three flops, change taken when last two agree
    // ------------------------------------------------------------------
    logic [3:0] pin_in;
    logic [3:0] sy1_q, sy2_q, sy3_q, pin_q;
    assign pin_in = {rx_data_pin, rx_start_pin, ext_field_pin, tx_end_pin};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sy1_q <= '0;
            sy2_q <= '0;
            sy3_q <= '0;
            pin_q <= '0;
        end else begin
            sy1_q <= pin_in;
            sy2_q <= sy1_q;
            sy3_q <= sy2_q;
            pin_q <= (sy2_q & sy3_q) | (pin_q & (sy2_q | sy3_q));
        end
    end
    logic pin_p_q;
    logic tx_end_ev;
    logic field_on, rx_start_lvl, rx_data_lvl;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_p_q <= 1'b0;
        end else begin
            pin_p_q <= pin_q[0];
        end
    end
    assign tx_end_ev = pin_q[0] & ~pin_p_q;
    assign field_on = pin_q[1];
    assign rx_start_lvl = pin_q[2];
    assign rx_data_lvl = pin_q[3];

    // ------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------
    logic [7:0] idx;
    logic wr, hit;
    logic sel_gain, sel_mask, sel_hi, sel_lo, sel_ctrl, sel_cmd, sel_stat;
    assign idx = paddr[9:2];
    assign wr = psel & penable & pwrite;
    assign sel_gain = idx == RXGT_IDX_GAIN;
    assign sel_mask = idx == RXGT_IDX_MASK;
    assign sel_hi = idx == RXGT_IDX_NRT_HI;
    assign sel_lo = idx == RXGT_IDX_NRT_LO;
    assign sel_ctrl = idx == RXGT_IDX_CTRL;
    assign sel_cmd = idx == RXGT_IDX_CMD;
    assign sel_stat = idx == RXGT_IDX_STAT;
    assign hit = (paddr[11:10] == 2'b00) & (paddr[1:0] == 2'b00) &
                 (sel_gain | sel_mask | sel_hi | sel_lo | sel_ctrl |
                  sel_cmd | sel_stat);

    logic cmd_reload, cmd_nrstart, cmd_default, cmd_clrirq;
    assign cmd_reload = wr & hit & sel_cmd & pwdata[RXGT_CMD_RELOAD];
    assign cmd_nrstart = wr & hit & sel_cmd & pwdata[RXGT_CMD_NRSTART];
    assign cmd_default = wr & hit & sel_cmd & pwdata[RXGT_CMD_DEFAULT];
    assign cmd_clrirq = wr & hit & sel_cmd & pwdata[RXGT_CMD_CLRIRQ];

    // ------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------
    logic [7:0] gain_q, mask_q, nrt_hi_q, nrt_lo_q, ctrl_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gain_q <= RXGT_GAIN_RST;
            mask_q <= RXGT_MASK_RST;
            nrt_hi_q <= RXGT_NRT_RST;
            nrt_lo_q <= RXGT_NRT_RST;
            ctrl_q <= RXGT_CTRL_RST;
        end else if (cmd_default) begin
            gain_q <= RXGT_GAIN_RST;
            mask_q <= RXGT_MASK_RST;
            nrt_hi_q <= RXGT_NRT_RST;
            nrt_lo_q <= RXGT_NRT_RST;
            ctrl_q <= RXGT_CTRL_RST;
        end else if (wr && hit) begin
            if (sel_gain) gain_q <= pwdata[7:0];
            if (sel_mask) mask_q <= pwdata[7:0];
            if (sel_hi) nrt_hi_q <= pwdata[7:0];
            if (sel_lo) nrt_lo_q <= pwdata[7:0];
            if (sel_ctrl) ctrl_q <= {3'h0, pwdata[4:0]};
        end
    end

    // ------------------------------------------------------------------
    // Gain load on reload command
    // ------------------------------------------------------------------
    // Unused codes above ten are clamped so the analog never sees them.
    logic [3:0] am_new, pm_new;
    assign am_new = (gain_q[RXGT_AM_LSB+:4] > RXGT_GAIN_MAX) ? RXGT_GAIN_MAX
                    : gain_q[RXGT_AM_LSB+:4];
    assign pm_new = (gain_q[RXGT_PM_LSB+:4] > RXGT_GAIN_MAX) ? RXGT_GAIN_MAX
                    : gain_q[RXGT_PM_LSB+:4];
    logic [3:0] am_code_q, pm_code_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            am_code_q <= RXGT_GAIN_RST[3:0];
            pm_code_q <= RXGT_GAIN_RST[3:0];
        end else if (cmd_default) begin
            am_code_q <= RXGT_GAIN_RST[3:0];
            pm_code_q <= RXGT_GAIN_RST[3:0];
        end else if (cmd_reload) begin
            am_code_q <= am_new;
            pm_code_q <= pm_new;
        end
    end
    // Each step is 3 dB: window steps up to four, then stage cuts.
    logic [3:0] am_win_d, pm_win_d, am_cut_d, pm_cut_d;
    assign am_win_d = (am_code_q > RXGT_WIN_MAX) ? RXGT_WIN_MAX
                      : am_code_q;
    assign pm_win_d = (pm_code_q > RXGT_WIN_MAX) ? RXGT_WIN_MAX
                      : pm_code_q;
    assign am_cut_d = am_code_q - am_win_d;
    assign pm_cut_d = pm_code_q - pm_win_d;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            am_window <= 2'h0;
            pm_window <= 2'h0;
            am_stage_cut <= 3'h0;
            pm_stage_cut <= 3'h0;
            am_stage23_gain_code <= 4'h0;
            pm_stage23_gain_code <= 4'h0;
        end else begin
            // Window field holds steps minus one when nonzero, code 0 full.
            am_window <= am_win_d[1:0] - {1'b0, |am_win_d};
            pm_window <= pm_win_d[1:0] - {1'b0, |pm_win_d};
            am_stage_cut <= am_cut_d[2:0];
            pm_stage_cut <= pm_cut_d[2:0];
            am_stage23_gain_code <= am_code_q;
            pm_stage23_gain_code <= pm_code_q;
        end
    end

    // ------------------------------------------------------------------
    // Mask receive timer
    // ------------------------------------------------------------------
    logic [7:0] mask_eff;
    logic [11:0] step_lim;
    logic [11:0] mpre_q;
    logic [7:0] mcnt_q;
    logic mask_q2;
    assign mask_eff = (mask_q <= RXGT_MASK_MIN) ? RXGT_MASK_MIN
                      : mask_q;
    assign step_lim = ctrl_q[RXGT_CTRL_BRD]
        ? 12'(RXGT_STEP_SHORT * RXGT_MASK_DIV - 1)
        : 12'(RXGT_STEP_SHORT - 1);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_q2 <= 1'b0;
            mpre_q <= 12'h000;
            mcnt_q <= 8'h00;
        end else if (tx_end_ev) begin
            mask_q2 <= 1'b1;
            mpre_q <= 12'h000;
            mcnt_q <= mask_eff;
        end else if (mask_q2) begin
            if (mpre_q == step_lim) begin
                mpre_q <= 12'h000;
                mcnt_q <= mcnt_q - 8'h01;
                if (mcnt_q == 8'h01) mask_q2 <= 1'b0;
            end else begin
                mpre_q <= mpre_q + 12'h001;
            end
        end
    end

    // ------------------------------------------------------------------
    // Automatic squelch window
    // ------------------------------------------------------------------
    logic [11:0] sq_cnt_q;
    logic sq_wait_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sq_cnt_q <= 12'h000;
            sq_wait_q <= 1'b0;
        end else if (tx_end_ev) begin
            sq_cnt_q <= 12'h000;
            sq_wait_q <= ctrl_q[RXGT_CTRL_SQEN];
        end else if (sq_wait_q && mask_q2) begin
            // Stops at the delay so a long mask cannot wrap it mid-window.
            if (sq_cnt_q != 12'(RXGT_SQ_DELAY_CYC)) begin
                sq_cnt_q <= sq_cnt_q + 12'h001;
            end
        end else begin
            sq_wait_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // No-response timer
    // ------------------------------------------------------------------
    // Interrupt is a sticky flag cleared by command; a new expiry wins.
    rxgt_nr_state_t nr_q;
    logic [15:0] nrt_full, ncnt_q;
    logic [11:0] npre_q, nstep_lim;
    logic irq_q, nr_trig, nr_start, nr_tick;
    assign nrt_full = {nrt_hi_q, nrt_lo_q};
    assign nstep_lim = ctrl_q[RXGT_CTRL_STEP]
        ? 12'(RXGT_STEP_LONG - 1)
        : 12'(RXGT_STEP_SHORT - 1);
    assign nr_trig = tx_end_ev;
    assign nr_start = (nrt_full != 16'h0000);
    assign nr_tick = npre_q == nstep_lim;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            nr_q <= RXGT_NR_IDLE;
            ncnt_q <= 16'h0000;
            npre_q <= 12'h000;
        end else if (cmd_default) begin
            nr_q <= RXGT_NR_IDLE;
        end else if ((cmd_nrstart || nr_trig) && nr_start) begin
            // Peer mode, not active, started by transmit end (not the start command): wait for the external field.
            nr_q <= (ctrl_q[RXGT_CTRL_P2P] && !ctrl_q[RXGT_CTRL_ACT]
                     && !field_on && !cmd_nrstart)
                    ? RXGT_NR_ARM : RXGT_NR_RUN;
            ncnt_q <= nrt_full;
            npre_q <= 12'h000;
        end else begin
            case (nr_q)
                RXGT_NR_IDLE: begin
                    npre_q <= 12'h000;
                end
                RXGT_NR_ARM: begin
                    if (field_on) nr_q <= RXGT_NR_RUN;
                end
                RXGT_NR_RUN: begin
                    if (rx_start_lvl) begin
                        nr_q <= RXGT_NR_IDLE;
                    end else if (nr_tick) begin
                        npre_q <= 12'h000;
                        ncnt_q <= ncnt_q - 16'h0001;
                        if (ncnt_q == 16'h0001) nr_q <= RXGT_NR_IDLE;
                    end else begin
                        npre_q <= npre_q + 12'h001;
                    end
                end
                default: nr_q <= RXGT_NR_IDLE;
            endcase
        end
    end
    logic nr_expire;
    assign nr_expire = (nr_q == RXGT_NR_RUN) && !rx_start_lvl && nr_tick &&
                       (ncnt_q == 16'h0001);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_q <= 1'b0;
        end else if (nr_expire) begin
            irq_q <= 1'b1;
        end else if (cmd_clrirq || cmd_default) begin
            irq_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Outputs and APB read
    // ------------------------------------------------------------------
    logic [31:0] rdat;
    assign rdat = !hit ? 32'h0000_0000
        : sel_gain ? {24'h0, gain_q}
        : sel_mask ? {24'h0, mask_q}
        : sel_hi ? {24'h0, nrt_hi_q}
        : sel_lo ? {24'h0, nrt_lo_q}
        : sel_ctrl ? {24'h0, ctrl_q}
        : sel_stat ? {25'h0, nr_q, 1'b0, squelch_active, mask_q2, irq_q}
        : 32'h0000_0000;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            rx_data_masked <= 1'b0;
            mask_active <= 1'b0;
            squelch_active <= 1'b0;
            no_response_irq <= 1'b0;
        end else begin
            pready <= psel & ~penable;
            pslverr <= psel & ~penable & ~hit;
            prdata <= (psel & ~penable & ~pwrite) ? rdat : prdata;
            rx_data_masked <= rx_data_lvl & ~mask_q2;
            mask_active <= mask_q2;
            squelch_active <= mask_q2 & sq_wait_q &
                (sq_cnt_q >= 12'(RXGT_SQ_DELAY_CYC));
            no_response_irq <= irq_q;
        end
    end
endmodule : rxgt_top

// file: hw/rxgt_pkg.sv
// Package with register map, field layout, reset values and timing counts.
package rxgt_pkg;
    // ------------------------------------------------------------------
    // Register indices; the byte address is four times the index.
    // ------------------------------------------------------------------
    localparam logic [7:0] RXGT_IDX_GAIN = 8'h0d;
    localparam logic [7:0] RXGT_IDX_MASK = 8'h0e;
    localparam logic [7:0] RXGT_IDX_NRT_HI = 8'h0f;
    localparam logic [7:0] RXGT_IDX_NRT_LO = 8'h10;
    localparam logic [7:0] RXGT_IDX_CTRL = 8'h20;
    localparam logic [7:0] RXGT_IDX_CMD = 8'h21;
    localparam logic [7:0] RXGT_IDX_STAT = 8'h22;
    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int RXGT_AM_LSB = 4;
    localparam int RXGT_PM_LSB = 0;
    localparam int RXGT_CTRL_STEP = 0;
    localparam int RXGT_CTRL_BRD = 1;
    localparam int RXGT_CTRL_P2P = 2;
    localparam int RXGT_CTRL_ACT = 3;
    localparam int RXGT_CTRL_SQEN = 4;
    localparam int RXGT_CMD_RELOAD = 0;
    localparam int RXGT_CMD_NRSTART = 1;
    localparam int RXGT_CMD_DEFAULT = 2;
    localparam int RXGT_CMD_CLRIRQ = 3;
    // ------------------------------------------------------------------
    // Reset values and limits
    // ------------------------------------------------------------------
    localparam logic [7:0] RXGT_GAIN_RST = 8'h00;
    localparam logic [7:0] RXGT_MASK_RST = 8'h08;
    localparam logic [7:0] RXGT_NRT_RST = 8'h00;
    localparam logic [7:0] RXGT_CTRL_RST = 8'h10;
    localparam logic [3:0] RXGT_GAIN_MAX = 4'ha;
    localparam logic [3:0] RXGT_WIN_MAX = 4'h4;
    localparam logic [7:0] RXGT_MASK_MIN = 8'h04;
    // ------------------------------------------------------------------
    // Timing, in carrier periods (pclk runs at fc), except the squelch delay in us at RXGT_CLK_MHZ
    // ------------------------------------------------------------------
    localparam int RXGT_STEP_SHORT = 64;
    localparam int RXGT_STEP_LONG = 4096;
    localparam int RXGT_MASK_DIV = 8;
    localparam real RXGT_SQ_DELAY_US = 18.88;
    localparam real RXGT_CLK_MHZ = 125.0;
    localparam int RXGT_SQ_DELAY_CYC = int'(RXGT_SQ_DELAY_US * RXGT_CLK_MHZ
                                           - 0.5);
    typedef enum logic [2:0] {
        RXGT_NR_IDLE = 3'b001,
        RXGT_NR_ARM = 3'b010,
        RXGT_NR_RUN = 3'b100
    } rxgt_nr_state_t;
endpackage : rxgt_pkg

// file: tb/rxgt_checker.sv
// Port-level assertions for the receive gain and response timer block.
`timescale 1ns/1ps
module rxgt_checker
    import rxgt_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Receive path
    input wire logic rx_data_masked,
    input wire logic mask_active,
    input wire logic [1:0] am_window,
    input wire logic [2:0] am_stage_cut,
    input wire logic [3:0] am_stage23_gain_code,
    input wire logic [3:0] pm_stage23_gain_code,
    input wire logic no_response_irq
);
    wire [7:0] idx = paddr[9:2];
    wire cmd_wr = psel & penable & pready & pwrite & (idx == RXGT_IDX_CMD);
    wire mapped = (paddr[11:10] == 2'h0) && (paddr[1:0] == 2'h0) &&
        ((idx >= RXGT_IDX_GAIN && idx <= RXGT_IDX_NRT_LO) ||
         (idx >= RXGT_IDX_CTRL && idx <= RXGT_IDX_STAT));
    wire [3:0] am_c = am_stage23_gain_code;
    wire [2:0] cut_exp = (am_c > 4'h4) ? 3'(am_c - 4'h4) : 3'h0;
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("no answer after setup");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("pready held too long");
    a_err_unmapped: assert property (pready |-> pslverr == !mapped)
        else $error("pslverr wrong for address");
    a_upper_bits_zero: assert property (
        pready && !pwrite |-> prdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    a_masked_quiet: assert property (
        mask_active && $past(mask_active) |-> !rx_data_masked)
        else $error("receiver output seen while masked");
    a_code_range: assert property (
        am_c <= RXGT_GAIN_MAX && pm_stage23_gain_code <= RXGT_GAIN_MAX)
        else $error("gain code above ten");
    a_cut_tracks: assert property (
        $stable(am_c) |-> am_stage_cut == cut_exp)
        else $error("stage cut does not match code");
    a_window_full: assert property (
        $stable(am_c) && am_c >= 4'h4 |-> am_window == 2'h3)
        else $error("window not widest");
    a_load_on_cmd: assert property (
        $changed(am_c) |-> $past(cmd_wr) || $past(cmd_wr, 2))
        else $error("gain code changed without command");
    a_irq_sticky: assert property (
        no_response_irq && !cmd_wr && !$past(cmd_wr) |=> no_response_irq)
        else $error("interrupt dropped by itself");
    c_cmd: cover property (cmd_wr);
    c_irq: cover property ($rose(no_response_irq));
    c_mask_end: cover property ($fell(mask_active));
endmodule : rxgt_checker

bind rxgt_top rxgt_checker i_chk (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .prdata, .pready, .pslverr, .rx_data_masked, .mask_active,
    .am_window, .am_stage_cut, .am_stage23_gain_code, .pm_stage23_gain_code,
    .no_response_irq);

// file: tb/rxgt_top_tb.sv
// Self-checking testbench for the receive gain and response timer block.
`timescale 1ns/1ps
module rxgt_top_tb;
    import rxgt_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, tx_end_pin = 1'b0, ext_field_pin = 1'b0;
    logic rx_start_pin = 1'b0, rx_data_pin = 1'b1;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata, rdat;
    logic pready, pslverr, rerr, rx_data_masked, mask_active, squelch_active;
    logic [1:0] am_window, pm_window;
    logic [2:0] am_stage_cut, pm_stage_cut;
    logic [3:0] am_stage23_gain_code, pm_stage23_gain_code;
    logic no_response_irq;
    int num_errors = 0, total_checks = 0;
    always #4 pclk = ~pclk;
    rxgt_top i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .tx_end_pin, .ext_field_pin,
        .rx_start_pin, .rx_data_pin, .rx_data_masked, .mask_active,
        .squelch_active, .am_window, .am_stage_cut, .pm_window, .pm_stage_cut,
        .am_stage23_gain_code, .pm_stage23_gain_code, .no_response_irq);
    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task automatic wrap_up;
        $display("checks %0d, mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : wrap_up
    task automatic tmo;
        num_errors++;
        $display("wrong value at %0t: wait ran out", $time);
        wrap_up;
    endtask : tmo
    task automatic check(input logic [31:0] got, exp, input string what);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: %s %h not %h", $time, what,
                     got, exp);
        end
    endtask : check
    task automatic range(input int got, lo, hi, input string what);
        check(32'(got >= lo && got <= hi), 32'h1, what);
    endtask : range
    task automatic apb(input logic w, input logic [7:0] idx,
                       input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
            if (++n > 16) tmo;
        end
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 32'h0);
        check(rdat, exp, "read");
    endtask : rd
    // The pin is held several cycles so the three-flop synchroniser sees it.
    task automatic tx_pulse;
        tx_end_pin <= 1'b1;
        repeat (8) @(posedge pclk);
        tx_end_pin <= 1'b0;
    endtask : tx_pulse
    task automatic mask_len(input int exp, input int sq);
        int t, len, sqo;
        t = 0;
        len = 0;
        sqo = 0;
        tx_pulse;
        while (mask_active !== 1'b1) begin
            @(posedge pclk);
            if (++t > 20) tmo;
        end
        while (mask_active === 1'b1) begin
            if (squelch_active === 1'b1 && sqo == 0) sqo = len;
            if (sqo > 0) check(squelch_active, 1, "squelch held");
            if (len > 1) check(rx_data_masked, 0, "masked data");
            @(posedge pclk);
            if (++len > 20000) tmo;
        end
        range(len, exp - 1, exp + 2, "mask length");
        if (sq > 0) range(sqo, sq - 5, sq + 5, "squelch start");
        repeat (3) @(posedge pclk);
        check(squelch_active, 0, "squelch end");
        check(rx_data_masked, 1, "unmasked data");
    endtask : mask_len
    // A negative lower bound means no interrupt may come within hi cycles.
    task automatic irq_wait(input int lo, input int hi);
        int t;
        t = 0;
        while (no_response_irq !== 1'b1 && t <= hi) begin
            @(posedge pclk);
            t++;
        end
        if (lo < 0) check(no_response_irq, 0, "irq");
        else range(t, lo, hi, "irq delay");
        apb(1'b1, RXGT_IDX_CMD, 32'h8);
        @(posedge pclk);
        check(no_response_irq, 0, "irq cleared");
    endtask : irq_wait
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_regs;
        rd(RXGT_IDX_GAIN, 32'h0);
        rd(RXGT_IDX_MASK, 32'h8);
        rd(RXGT_IDX_NRT_HI, 32'h0);
        rd(RXGT_IDX_NRT_LO, 32'h0);
        rd(RXGT_IDX_CTRL, 32'h10);
        rd(RXGT_IDX_STAT, 32'h10);
        rd(8'h30, 32'h0);
        check(rerr, 1, "unmapped error");
        apb(1'b1, RXGT_IDX_GAIN, 32'h33);
        apb(1'b1, RXGT_IDX_MASK, 32'h20);
        apb(1'b1, RXGT_IDX_NRT_LO, 32'h5);
        rd(RXGT_IDX_GAIN, 32'h33);
        rd(RXGT_IDX_NRT_LO, 32'h5);
        apb(1'b1, RXGT_IDX_CMD, 32'h4);
        rd(RXGT_IDX_GAIN, 32'h0);
        rd(RXGT_IDX_MASK, 32'h8);
        rd(RXGT_IDX_NRT_LO, 32'h0);
        $display("test registers done");
    endtask : t_regs
    task automatic t_gain;
        logic [3:0] e;
        apb(1'b1, RXGT_IDX_GAIN, 32'ha2);
        check(am_stage23_gain_code, 0, "code before reload");
        for (int c = 0; c < 16; c++) begin
            e = (c > 10) ? 4'ha : 4'(c);
            apb(1'b1, RXGT_IDX_GAIN, {24'h0, 4'(c), 4'h5});
            apb(1'b1, RXGT_IDX_CMD, 32'h1);
            repeat (2) @(posedge pclk);
            check(am_stage23_gain_code, e, "am code");
            check(am_stage_cut, (e > 4) ? e - 4 : 0, "am cut");
            check(am_window, (e >= 4) ? 3 : (e > 0) ? e - 1 : 0, "am win");
            check(pm_stage23_gain_code, 5, "pm code");
            check(pm_stage_cut, 1, "pm cut");
            check(pm_window, 3, "pm window");
        end
        $display("test gain done");
    endtask : t_gain
    task automatic t_mask;
        mask_len(512, 0);
        apb(1'b1, RXGT_IDX_MASK, 32'h0);
        mask_len(256, 0);
        apb(1'b1, RXGT_IDX_MASK, 32'hff);
        mask_len(16320, 2359);
        apb(1'b1, RXGT_IDX_CTRL, 32'h12);
        apb(1'b1, RXGT_IDX_MASK, 32'h4);
        mask_len(2048, 0);
        $display("test mask done");
    endtask : t_mask
    task automatic t_nrt;
        apb(1'b1, RXGT_IDX_CTRL, 32'h10);
        apb(1'b1, RXGT_IDX_NRT_LO, 32'h2);
        tx_pulse;
        irq_wait(116, 138);
        apb(1'b1, RXGT_IDX_NRT_LO, 32'h0);
        tx_pulse;
        irq_wait(-1, 300);
        apb(1'b1, RXGT_IDX_NRT_HI, 32'h1);
        tx_pulse;
        irq_wait(16372, 16394);
        apb(1'b1, RXGT_IDX_NRT_HI, 32'h0);
        apb(1'b1, RXGT_IDX_NRT_LO, 32'h4);
        tx_pulse;
        repeat (50) @(posedge pclk);
        rx_start_pin <= 1'b1;
        irq_wait(-1, 400);
        rx_start_pin <= 1'b0;
        apb(1'b1, RXGT_IDX_CTRL, 32'h11);
        apb(1'b1, RXGT_IDX_NRT_LO, 32'h1);
        tx_pulse;
        irq_wait(4084, 4106);
        $display("test no-response done");
    endtask : t_nrt
    task automatic t_start;
        apb(1'b1, RXGT_IDX_CTRL, 32'h10);
        apb(1'b1, RXGT_IDX_NRT_LO, 32'h3);
        apb(1'b1, RXGT_IDX_CMD, 32'h2);
        repeat (100) @(posedge pclk);
        apb(1'b1, RXGT_IDX_CMD, 32'h2);
        irq_wait(186, 196);
        apb(1'b1, RXGT_IDX_CTRL, 32'h14);
        apb(1'b1, RXGT_IDX_NRT_LO, 32'h1);
        tx_pulse;
        irq_wait(-1, 200);
        ext_field_pin <= 1'b1;
        irq_wait(60, 74);
        ext_field_pin <= 1'b0;
        apb(1'b1, RXGT_IDX_CTRL, 32'h1c);
        tx_pulse;
        irq_wait(58, 68);
        $display("test start and peer done");
    endtask : t_start
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs;
        t_gain;
        t_mask;
        t_nrt;
        t_start;
        wrap_up;
    end
endmodule : rxgt_top_tb
